// ---- include/lst_pkg.sv ----
// lst_pkg: shared constants for the lcd scan timing and power control block
// assumes a 50 MHz system clock and a classic wishbone register bus
package lst_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00; // clock src, dir, duty, master
    localparam logic [7:0] REG_POWER = 8'h04; // booster, regulator, follower
    localparam logic [7:0] REG_VOLUME = 8'h08; // electronic volume
    localparam logic [7:0] REG_START = 8'h0c; // display start line
    localparam logic [7:0] REG_STATUS = 8'h10; // scan state
    localparam logic [7:0] REG_WADDR = 8'h14; // host ram address (line*8+word)
    localparam logic [7:0] REG_WDATA = 8'h18; // host ram data window
    // ctrl fields
    localparam int CTRL_EXT_CLK = 0;
    localparam int CTRL_REV = 1;
    localparam int CTRL_DUTY_LO = 2;
    localparam int CTRL_MASTER = 5;
    // power fields
    localparam int PWR_FOLLOWER = 0;
    localparam int PWR_REGULATOR = 1;
    localparam int PWR_BOOSTER = 2;
    // duty encodings
    localparam logic [2:0] DUTY_65 = 3'h0;
    localparam logic [2:0] DUTY_49 = 3'h1;
    localparam logic [2:0] DUTY_33 = 3'h2;
    localparam logic [2:0] DUTY_55 = 3'h3;
    localparam logic [2:0] DUTY_53 = 3'h4;
    // last common line for each duty
    localparam logic [5:0] LAST_65 = 6'h3f;
    localparam logic [5:0] LAST_49 = 6'h2f;
    localparam logic [5:0] LAST_33 = 6'h1f;
    localparam logic [5:0] LAST_55 = 6'h35;
    localparam logic [5:0] LAST_53 = 6'h33;
    localparam int NUM_COM = 64;
    localparam int NUM_SEG = 132;
    localparam int RAM_LINES = 65;
    localparam int ICON_LINE = 64;
    // reset values
    localparam logic [5:0] VOLUME_RST = 6'h20;
    localparam logic [5:0] CTRL_RST = 6'h20;
    // display clock: system clocks per line slot
    localparam int SYS_CLK_HZ = 50000000;
    localparam int LINE_RATE_HZ = 5000;
    localparam int LINE_DIV = SYS_CLK_HZ / LINE_RATE_HZ;
    // scan states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_LATCH = 2'b11
    } lst_scan_t;
endpackage

// ---- hdl/lst_ram.sv ----
// lst_ram: display ram, one host write port and one refresh read port
// assumes both ports run on the same clock; read data is registered
`timescale 1ns/1ps
module lst_ram #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 65 * 8,
    parameter int AW = 10
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    // separate ports keep refresh reads apart from host writes
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_ff[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rdata_o <= mem_ff[raddr_i];
    end
endmodule

// ---- hdl/lst_sync.sv ----
// lst_sync: two-flop synchroniser with edge pulse on the synced level
// assumes the input is asynchronous to clk_i
`timescale 1ns/1ps
module lst_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic rise_o
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // first flop read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
            rise_o <= sync_ff & ~last_ff;
        end
    end
endmodule

// ---- hdl/lst_top.sv ----
// lst_top: lcd scan timing, common scan, frame alternation and power control
// assumes a wishbone classic master on clk_i and an external display clock pin
// Operation
// R1: timing pulses drive line counter and latch
// R2: ram line latched per display clock, to segments
// R3: refresh reads independent of host ram access
// R4: frame alternation toggles each frame, two-frame ac
// R5: scan direction and end line per duty
// R6: reduced duty halves at pin range ends; icon always
// R7: output level from pixel, common state, alternation; here level is pixel xor alternation only
// R8: power bits: booster, regulator, follower
// R9: each supply stage switched independently
// R10: supply stages respond only in master mode
// R11: host uses recommended power combinations
// R12: 64-level electronic volume held
// R13: clock select low uses external clock pin; here CTRL_EXT_CLK high selects the pin, low the internal divider
// R14: start line chooses first displayed ram line
`timescale 1ns/1ps
module lst_top #(
    parameter int LINE_DIV = lst_pkg::LINE_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic external_display_clock_pin_i,
    output logic [lst_pkg::NUM_SEG-1:0] segment_output_o,
    output logic [lst_pkg::NUM_SEG-1:0] segment_level_o,
    output logic [lst_pkg::NUM_COM-1:0] common_select_o,
    output logic common_icon_o,
    output logic frame_alternation_signal_o,
    output logic booster_on_o,
    output logic regulator_on_o,
    output logic follower_on_o,
    output logic [5:0] internal_reference_level_o
);
    logic [5:0] ctrl_ff;
    logic [2:0] power_ff;
    logic [5:0] volume_ff;
    logic [5:0] start_ff;
    logic [9:0] waddr_ff;
    logic [15:0] div_ff;
    logic int_tick;
    logic ext_tick;
    logic line_tick;
    logic [6:0] line_ff;
    logic [5:0] last_line;
    logic [6:0] ram_line;
    logic [2:0] word_ff;
    logic [9:0] raddr;
    logic [31:0] rdata;
    logic [lst_pkg::NUM_SEG-1:0] fetch_ff;
    lst_pkg::lst_scan_t state_ff;
    logic wb_req;
    logic ram_we;
    logic [5:0] phys_com;
    logic [5:0] half;
    logic [6:0] logical;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign ram_we = wb_req & wb_we_i & (wb_adr_i == lst_pkg::REG_WDATA);

    // wishbone ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // register writes; sel byte 0 covers all narrow fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= lst_pkg::CTRL_RST;
            power_ff <= 3'h0;
            volume_ff <= lst_pkg::VOLUME_RST;
            start_ff <= 6'h00;
        end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                lst_pkg::REG_CTRL: ctrl_ff <= wb_dat_i[5:0];
                lst_pkg::REG_POWER: power_ff <= wb_dat_i[2:0]; // see R8 see R9
                lst_pkg::REG_VOLUME: volume_ff <= wb_dat_i[5:0]; // see R12
                lst_pkg::REG_START: start_ff <= wb_dat_i[5:0]; // see R14
                default: ;
            endcase
        end
    end

    // host address pointer, auto-increments on each data write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            waddr_ff <= 10'h000;
        end else if (wb_req && wb_we_i && wb_adr_i == lst_pkg::REG_WADDR) begin
            waddr_ff <= wb_dat_i[9:0];
        end else if (ram_we) begin
            waddr_ff <= waddr_ff + 10'h001;
        end
    end

    // read mux; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                lst_pkg::REG_CTRL: wb_dat_o <= {26'h0, ctrl_ff};
                lst_pkg::REG_POWER: wb_dat_o <= {29'h0, power_ff};
                lst_pkg::REG_VOLUME: wb_dat_o <= {26'h0, volume_ff};
                lst_pkg::REG_START: wb_dat_o <= {26'h0, start_ff};
                lst_pkg::REG_STATUS:
                    wb_dat_o <= {22'h0, frame_alternation_signal_o, line_ff, state_ff};
                lst_pkg::REG_WADDR: wb_dat_o <= {22'h0, waddr_ff};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // refresh has its own ram port so host writes never stall it
    lst_ram u_ram ( // see R3
        .clk_i(clk_i),
        .we_i(ram_we),
        .waddr_i(waddr_ff),
        .wdata_i(wb_dat_i),
        .raddr_i(raddr),
        .rdata_o(rdata)
    );

    lst_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(external_display_clock_pin_i),
        .rise_o(ext_tick)
    );

    // internal oscillator stands still while the external pin is chosen
    always_ff @(posedge clk_i) begin
        if (rst_i || ctrl_ff[lst_pkg::CTRL_EXT_CLK]) begin // see R13
            div_ff <= 16'h0000;
        end else if (div_ff == 16'(LINE_DIV - 1)) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end
    assign int_tick = ~ctrl_ff[lst_pkg::CTRL_EXT_CLK] && (div_ff == 16'(LINE_DIV - 1));
    assign line_tick = ctrl_ff[lst_pkg::CTRL_EXT_CLK] ? ext_tick : int_tick; // see R13 see R1

    // last line per duty
    always_comb begin
        case (ctrl_ff[lst_pkg::CTRL_DUTY_LO +: 3]) // see R5
            lst_pkg::DUTY_49: last_line = lst_pkg::LAST_49;
            lst_pkg::DUTY_33: last_line = lst_pkg::LAST_33;
            lst_pkg::DUTY_55: last_line = lst_pkg::LAST_55;
            lst_pkg::DUTY_53: last_line = lst_pkg::LAST_53;
            default: last_line = lst_pkg::LAST_65;
        endcase
    end

    // line counter: 0..last then one icon slot, then next frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_ff <= 7'h00;
            frame_alternation_signal_o <= 1'b0;
        end else if (line_tick) begin // see R1
            if (line_ff == 7'(lst_pkg::ICON_LINE)) begin
                line_ff <= 7'h00;
                frame_alternation_signal_o <= ~frame_alternation_signal_o; // see R4
            end else if (line_ff[5:0] == last_line) begin
                line_ff <= 7'(lst_pkg::ICON_LINE);
            end else begin
                line_ff <= line_ff + 7'h01;
            end
        end
    end

    // ram line: start offset wraps within the 64 main lines; icon fixed
    assign ram_line = (line_ff == 7'(lst_pkg::ICON_LINE)) ? line_ff :
                      {1'b0, line_ff[5:0] + start_ff}; // see R14
    assign raddr = {ram_line, word_ff};

    // fetch five words per line then latch; read data lags one cycle
    // a line tick that lands mid-fetch is lost, so ticks need seven clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= lst_pkg::ST_IDLE;
            word_ff <= 3'h0;
            fetch_ff <= '0;
        end else begin
            case (state_ff)
                lst_pkg::ST_IDLE: begin
                    word_ff <= 3'h0;
                    if (line_tick) begin
                        state_ff <= lst_pkg::ST_FETCH; // see R1
                    end
                end
                lst_pkg::ST_FETCH: begin
                    word_ff <= word_ff + 3'h1;
                    if (word_ff != 3'h0) begin
                        fetch_ff[(word_ff - 3'h1) * 32 +: 32] <= rdata; // see R2
                    end
                    if (word_ff == 3'h4) begin
                        state_ff <= lst_pkg::ST_LATCH;
                    end
                end
                lst_pkg::ST_LATCH: begin
                    fetch_ff[128 +: 4] <= rdata[3:0];
                    state_ff <= lst_pkg::ST_IDLE;
                end
                default: state_ff <= lst_pkg::ST_IDLE;
            endcase
        end
    end

    // map logical scan line to physical common pin, halves at both ends
    always_comb begin
        logical = line_ff;
        if (ctrl_ff[lst_pkg::CTRL_REV]) begin // see R5
            logical = {1'b0, last_line - line_ff[5:0]};
        end
        half = (last_line >> 1) + 6'h01;
        if (logical[5:0] < half) begin // see R6
            phys_com = logical[5:0];
        end else begin
            phys_com = 6'(logical[5:0] + 6'(lst_pkg::NUM_COM - 1) - last_line);
        end
    end

    // latch line data and common selection together at end of fetch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            segment_output_o <= '0;
            segment_level_o <= '0;
            common_select_o <= '0;
            common_icon_o <= 1'b0;
        end else if (state_ff == lst_pkg::ST_LATCH) begin
            segment_output_o <= {rdata[3:0], fetch_ff[127:0]}; // see R2
            // drive level: pixel xor alternation phase
            segment_level_o <= {rdata[3:0], fetch_ff[127:0]} ^
                               {lst_pkg::NUM_SEG{frame_alternation_signal_o}}; // see R7
            common_select_o <= '0;
            common_icon_o <= (line_ff == 7'(lst_pkg::ICON_LINE)); // see R6
            if (line_ff != 7'(lst_pkg::ICON_LINE)) begin
                common_select_o[phys_com] <= 1'b1; // see R7
            end
        end
    end

    // supply stages follow their bits only in master mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            booster_on_o <= 1'b0;
            regulator_on_o <= 1'b0;
            follower_on_o <= 1'b0;
            internal_reference_level_o <= lst_pkg::VOLUME_RST;
        end else begin
            booster_on_o <= ctrl_ff[lst_pkg::CTRL_MASTER] & power_ff[lst_pkg::PWR_BOOSTER]; // see R10
            regulator_on_o <= ctrl_ff[lst_pkg::CTRL_MASTER] & power_ff[lst_pkg::PWR_REGULATOR];
            follower_on_o <= ctrl_ff[lst_pkg::CTRL_MASTER] & power_ff[lst_pkg::PWR_FOLLOWER];
            internal_reference_level_o <= volume_ff; // see R12
        end
    end
endmodule

// ---- test/lst_properties.sv ----
// lst_checker: port-level assertions for lst_top
// assumes it is bound into lst_top and sees one clock domain
`timescale 1ns/1ps
module lst_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [lst_pkg::NUM_SEG-1:0] segment_output_o,
    input wire logic [lst_pkg::NUM_SEG-1:0] segment_level_o,
    input wire logic [lst_pkg::NUM_COM-1:0] common_select_o,
    input wire logic common_icon_o,
    input wire logic frame_alternation_signal_o,
    input wire logic booster_on_o,
    input wire logic regulator_on_o,
    input wire logic follower_on_o,
    input wire logic [5:0] internal_reference_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] pwr_ff;
    logic mst_ff;
    logic [5:0] vol_ff;
    logic wr_hit;
    logic quiet;
    assign wr_hit = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    // shadows trail the bus by a cycle, so checks wait for a quiet bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_ff <= 3'h0;
            mst_ff <= 1'b1;
            vol_ff <= 6'h20;
        end else if (wr_hit) begin
            if (wb_adr_i == lst_pkg::REG_POWER) pwr_ff <= wb_dat_i[2:0];
            if (wb_adr_i == lst_pkg::REG_CTRL) mst_ff <= wb_dat_i[5];
            if (wb_adr_i == lst_pkg::REG_VOLUME) vol_ff <= wb_dat_i[5:0];
        end
    end
    // no ack in the previous cycle; the checks add this cycle and the one two back
    always_ff @(posedge clk_i) begin
        quiet <= !wb_ack_o && !wr_hit;
    end
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ans_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_bus_answer: assert property (req_s |=> ans_s)
        else $error("bus request not answered by one ack pulse");
    chk_power_gate: assert property (
        quiet && !wb_ack_o && !$past(wb_ack_o, 2) |->
        {booster_on_o, regulator_on_o, follower_on_o} == (mst_ff ? pwr_ff : 3'h0))
        else $error("supply stage enables differ from written bits");
    chk_volume_hold: assert property (
        quiet && !wb_ack_o && !$past(wb_ack_o, 2) |-> internal_reference_level_o == vol_ff)
        else $error("volume level differs from written value");
    chk_reset_state: assert property (
        $fell(rst_i) |-> internal_reference_level_o == 6'h20 && !booster_on_o)
        else $error("wrong output values after reset");
    chk_common_onehot: assert property ($onehot0(common_select_o))
        else $error("more than one common line active");
    chk_icon_slot: assert property (common_icon_o |-> common_select_o == '0)
        else $error("common line active during icon slot");
    // level is mixed at the latch; alternation may flip again before the next latch
    chk_level_mix: assert property (
        $changed(segment_output_o) || $changed(segment_level_o) |->
        segment_level_o == (segment_output_o ^ {lst_pkg::NUM_SEG{frame_alternation_signal_o}}))
        else $error("segment level not pixel mixed with alternation");
    chk_fr_wrap: assert property (
        $changed(frame_alternation_signal_o) |-> $past(common_icon_o) || $past(common_icon_o, 2))
        else $error("alternation toggled away from frame wrap");
    chk_latch_step: assert property (
        $changed(segment_output_o) |-> $changed({common_icon_o, common_select_o}))
        else $error("segment data changed outside a line step");
endmodule
bind lst_top lst_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .segment_output_o(segment_output_o),
    .segment_level_o(segment_level_o), .common_select_o(common_select_o),
    .common_icon_o(common_icon_o), .frame_alternation_signal_o(frame_alternation_signal_o),
    .booster_on_o(booster_on_o), .regulator_on_o(regulator_on_o),
    .follower_on_o(follower_on_o), .internal_reference_level_o(internal_reference_level_o));

// ---- test/lst_panel.sv ----
// lst_panel: passive glass model, counts line slots per frame
// assumes it samples settled design outputs on the system clock
`timescale 1ns/1ps
module lst_panel (
    input wire logic clk_i,
    input wire logic [63:0] com_i,
    input wire logic icon_i,
    input wire logic fr_i,
    input wire logic [31:0] lvl_i,
    output int frames_o,
    output int slots_o,
    output logic [63:0] first_com_o,
    output logic [31:0] first_pix_o
);
    logic [64:0] prev = '0;
    logic fr_old = 1'b0;
    logic grab = 1'b0;
    int cnt = 0;
    // a frame ends when alternation flips; the glass decodes pixels back from it
    always @(posedge clk_i) begin
        if ({icon_i, com_i} !== prev) cnt++;
        prev = {icon_i, com_i};
        if (fr_i !== fr_old) begin
            frames_o++;
            slots_o = cnt;
            cnt = 0;
            grab = 1'b1;
        end
        fr_old = fr_i;
        if (grab && com_i != '0) begin
            first_com_o = com_i;
            first_pix_o = lvl_i ^ {32{fr_i}};
            grab = 1'b0;
        end
    end
endmodule

// ---- test/tb_lst_top.sv ----
// tb_lst_top: self-checking bench for lst_top
// assumes the bound checker and the glass model beside it
`timescale 1ns/1ps
module tb_lst_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat, q;
    logic [31:0] mem_q[$];
    logic ext_pin = 1'b0;
    logic ack, icon, fr, boost, regu, foll;
    logic [lst_pkg::NUM_SEG-1:0] segment_output, lvl;
    logic [63:0] com, first_com;
    logic [31:0] first_pix;
    logic [5:0] vref;
    int fail_count = 0;
    int cmp_count = 0;
    int frames, slots, vol_m, f_idle;
    int start_m = 0;
    int pwr_q[$] = '{7, 3, 1, 0, 2, 4, 5, 6};
    int last_q[$] = '{63, 47, 31, 53, 51};
    always #10 clk_i = ~clk_i;
    // a line slot must outlast the six-cycle fetch, so eight clocks per line
    lst_top #(.LINE_DIV(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .external_display_clock_pin_i(ext_pin),
        .segment_output_o(segment_output), .segment_level_o(lvl), .common_select_o(com),
        .common_icon_o(icon), .frame_alternation_signal_o(fr), .booster_on_o(boost),
        .regulator_on_o(regu), .follower_on_o(foll), .internal_reference_level_o(vref));
    lst_panel panel_u (.clk_i(clk_i), .com_i(com), .icon_i(icon), .fr_i(fr),
        .lvl_i(lvl[31:0]), .frames_o(frames), .slots_o(slots), .first_com_o(first_com),
        .first_pix_o(first_pix));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one classic cycle, held until ack is seen high at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (ack !== 1'b1) begin
            fail_count++;
            end_sim();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // lets frames pass so the count comes from a whole frame
    // mode changes land in the icon slot, so no common pin shows twice in a row
    task automatic scan(input int duty, input int rev, input int ext);
        int f0;
        int t;
        t = 0;
        while (icon !== 1'b1 && t < 2000) begin
            @(posedge clk_i);
            t++;
        end
        if (icon !== 1'b1) begin
            fail_count++;
            end_sim();
        end
        wb(1'b1, lst_pkg::REG_CTRL, 32'h20 | (duty << 2) | (rev << 1) | ext);
        f0 = frames;
        t = 0;
        // in external mode the pin rises every eight clocks, idle otherwise
        while (frames < f0 + 3 && t < 20000) begin
            @(posedge clk_i);
            t++;
            if (ext != 0 && t % 4 == 0) ext_pin <= ~ext_pin;
        end
        if (t >= 20000) begin
            fail_count++;
            end_sim();
        end
        chk(slots, last_q[duty] + 2);
        chk({31'h0, first_com == (64'h1 << (rev ? 63 : 0))}, 32'h1);
        chk(first_pix, mem_q[start_m * 8]);
    endtask
    // main sequence
    initial begin
        void'($urandom(17));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, lst_pkg::REG_CTRL, 32'h0);
        chk(q, 32'h20);
        chk({26'h0, vref}, 32'h20);
        $display("test reset done");
        // external clock chosen with the pin idle: no line may advance
        wb(1'b1, lst_pkg::REG_CTRL, 32'h21);
        f_idle = frames;
        wb(1'b1, lst_pkg::REG_START, 32'h0);
        wb(1'b1, lst_pkg::REG_WADDR, 32'h0);
        // every word filled so the refresh never latches unknown pixels
        for (int k = 0; k < lst_pkg::RAM_LINES * 8; k++) begin
            mem_q.push_back($urandom);
            wb(1'b1, lst_pkg::REG_WDATA, mem_q[k]);
        end
        chk(frames, f_idle);
        wb(1'b1, lst_pkg::REG_CTRL, 32'h20);
        $display("test ram fill done");
        foreach (pwr_q[i]) begin
            wb(1'b1, lst_pkg::REG_POWER, pwr_q[i]);
            repeat (3) @(posedge clk_i);
            chk({29'h0, boost, regu, foll}, pwr_q[i]);
        end
        wb(1'b1, lst_pkg::REG_CTRL, 32'h0);
        wb(1'b1, lst_pkg::REG_POWER, 32'h7);
        repeat (3) @(posedge clk_i);
        chk({29'h0, boost, regu, foll}, 32'h0);
        $display("test power done");
        repeat (4) begin
            vol_m = $urandom & 63;
            wb(1'b1, lst_pkg::REG_VOLUME, vol_m);
            wb(1'b0, lst_pkg::REG_VOLUME, 32'h0);
            chk(q, vol_m);
            chk({26'h0, vref}, vol_m);
        end
        wb(1'b1, 8'h1c, 32'hffff_ffff);
        wb(1'b0, 8'h1c, 32'h0);
        chk(q, 32'h0);
        chk({26'h0, vref}, vol_m);
        $display("test volume done");
        for (int d = 0; d < 5; d++) begin
            scan(d, 0, 0);
            scan(d, 1, 0);
        end
        start_m = $urandom & 63;
        wb(1'b1, lst_pkg::REG_START, start_m);
        scan(0, 0, 1);
        $display("test scan done");
        end_sim();
    end
endmodule
